// [swmc_consts.vh]
// constants for the standby wake-up mode control block
// assumes a 32-bit register bus with one aligned word per register
`ifndef SWMC_CONSTS_VH
`define SWMC_CONSTS_VH

// byte offsets
`define SWMC_OFF_BANK_E     8'h00
`define SWMC_OFF_BANK_F     8'h04
`define SWMC_OFF_STATUS     8'h08
`define SWMC_OFF_MASK       8'h0C
`define SWMC_OFF_CLEAR      8'h10

// field positions inside one source slot
`define SWMC_LVL_LSB        4
`define SWMC_EDGE_LSB       2
`define SWMC_EN_BIT         0
// slot bases: bank e sources 0..2, bank f sources 3..4
`define SWMC_SLOT_HI        16
`define SWMC_SLOT_MID       8
`define SWMC_SLOT_LO        0

// active-level codes
`define SWMC_LVL_LOW        3'h0
`define SWMC_LVL_HIGH       3'h1
`define SWMC_LVL_FALL       3'h2
`define SWMC_LVL_RISE       3'h3
`define SWMC_LVL_BOTH       3'h4

// edge record codes
`define SWMC_EDGE_NONE      2'h0
`define SWMC_EDGE_RISE      2'h1
`define SWMC_EDGE_FALL      2'h2
`define SWMC_EDGE_BOTH      2'h3

// reset values
`define SWMC_LVL_RST        3'h2
`define SWMC_MASK_RST       5'h00
// bank e bits 30:28 and 24 are plain storage
`define SWMC_SPARE_LSB      28
`define SWMC_SPARE_BIT      24
`define SWMC_SPARE_RST      3'h2

// axi responses
`define SWMC_RESP_OKAY      2'h0
`define SWMC_RESP_SLVERR    2'h2

`endif

// [swmc_src_sync.v]
// two-stage synchroniser and edge detector for the wake request lines
// assumes the request lines are asynchronous to aclk
`timescale 1ns/1ps
module swmc_src_sync #(
	parameter N = 5
) (
	input  wire         aclk,
	input  wire         aresetn,
	input  wire [N-1:0] req_async,
	output reg  [N-1:0] lvl_ff,
	output wire [N-1:0] rise,
	output wire [N-1:0] fall
);
	reg [N-1:0] meta_ff;
	reg [N-1:0] prev_ff;

	// meta_ff feeds only lvl_ff
	always @(posedge aclk) begin
		if (!aresetn) begin
			meta_ff <= {N{1'b0}};
			lvl_ff  <= {N{1'b0}};
			prev_ff <= {N{1'b0}};
		end else begin
			meta_ff <= req_async;
			lvl_ff  <= meta_ff;
			prev_ff <= lvl_ff;
		end
	end

	assign rise = lvl_ff & ~prev_ff;
	assign fall = ~lvl_ff & prev_ff;
endmodule

// [swmc_wake_ctrl.v]
// standby wake-up mode control: two mode banks, wake detection, irq
// assumes an AXI4-Lite master on aclk and async peripheral request lines
//
// Notes on behaviour
// - read-only two-bit detected edge fields
// - request forwarded only while enable is one
// - edge record updates only in both-edges mode
// - interrupt clear also zeroes edge record
// - level codes decoded; 101 to 111 prohibited
`timescale 1ns/1ps
`include "swmc_consts.vh"
module swmc_wake_ctrl #(
	parameter NSRC = 5
) (
	input  wire            aclk,
	input  wire            aresetn,
	input  wire [31:0]     s_axi_awaddr,
	input  wire            s_axi_awvalid,
	output reg             s_axi_awready,
	input  wire [31:0]     s_axi_wdata,
	input  wire [3:0]      s_axi_wstrb,
	input  wire            s_axi_wvalid,
	output reg             s_axi_wready,
	output reg  [1:0]      s_axi_bresp,
	output reg             s_axi_bvalid,
	input  wire            s_axi_bready,
	input  wire [31:0]     s_axi_araddr,
	input  wire            s_axi_arvalid,
	output reg             s_axi_arready,
	output reg  [31:0]     s_axi_rdata,
	output reg  [1:0]      s_axi_rresp,
	output reg             s_axi_rvalid,
	input  wire            s_axi_rready,
	input  wire            remote_rx_request,
	input  wire            cec_tx_request,
	input  wire            cec_rx_request,
	input  wire            key_wake_request,
	input  wire            rtc_wake_request,
	output reg  [NSRC-1:0] wake_request_ff,
	output reg             irq_ff
);
	////////////////////////////////////////////////////////////////////
	// per-source state; index 0 remote rx, 1 cec tx, 2 cec rx, 3 key, 4 rtc
	reg  [2:0]      lvl_sel_ff [0:NSRC-1];
	reg  [1:0]      edge_rec_ff[0:NSRC-1];
	reg  [NSRC-1:0] wake_en_ff;
	reg  [NSRC-1:0] status_ff;
	reg  [NSRC-1:0] mask_ff;
	wire [NSRC-1:0] req_lvl;
	wire [NSRC-1:0] req_rise;
	wire [NSRC-1:0] req_fall;
	wire [NSRC-1:0] hit;
	reg  [NSRC-1:0] clr_pulse;

	// one-hot register selects
	localparam [4:0] SEL_E   = 5'h01;
	localparam [4:0] SEL_F   = 5'h02;
	localparam [4:0] SEL_STS = 5'h04;
	localparam [4:0] SEL_MSK = 5'h08;
	localparam [4:0] SEL_CLR = 5'h10;

	swmc_src_sync #(
		.N(NSRC)
	) u_sync (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.req_async ({rtc_wake_request, key_wake_request, cec_rx_request,
		             cec_tx_request, remote_rx_request}),
		.lvl_ff    (req_lvl),
		.rise      (req_rise),
		.fall      (req_fall)
	);

	// level decode; prohibited codes never match
	function active;
		input [2:0] sel;
		input       l;
		input       r;
		input       f;
		begin
			case (sel)
				`SWMC_LVL_LOW:  active = ~l;
				`SWMC_LVL_HIGH: active = l;
				`SWMC_LVL_FALL: active = f;
				`SWMC_LVL_RISE: active = r;
				`SWMC_LVL_BOTH: active = r | f;
				default:        active = 1'b0;
			endcase
		end
	endfunction

	// slot base bit of source i within its bank
	function [4:0] slot_base;
		input integer i;
		begin
			case (i)
				0:       slot_base = `SWMC_SLOT_HI;
				1:       slot_base = `SWMC_SLOT_MID;
				3:       slot_base = `SWMC_SLOT_MID;
				default: slot_base = `SWMC_SLOT_LO;
			endcase
		end
	endfunction

	// full-address decode so that aliases above the map answer with an error
	function [4:0] reg_dec;
		input [31:0] a;
		begin
			reg_dec = 5'h00;
			if (a[31:8] == 24'h000000) begin
				case (a[7:0])
					`SWMC_OFF_BANK_E: reg_dec = SEL_E;
					`SWMC_OFF_BANK_F: reg_dec = SEL_F;
					`SWMC_OFF_STATUS: reg_dec = SEL_STS;
					`SWMC_OFF_MASK:   reg_dec = SEL_MSK;
					`SWMC_OFF_CLEAR:  reg_dec = SEL_CLR;
					default:          reg_dec = 5'h00;
				endcase
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// axi4-lite write: address and data accepted in either order
	reg        aw_hold_ff;
	reg        w_hold_ff;
	reg [4:0]  aw_sel_ff;
	reg [31:0] w_data_ff;
	reg [3:0]  w_strb_ff;
	wire       aw_take = s_axi_awvalid & s_axi_awready;
	wire       w_take  = s_axi_wvalid & s_axi_wready;
	wire       wr_go   = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;
	wire       wr_e    = wr_go & aw_sel_ff[0];
	wire       wr_f    = wr_go & aw_sel_ff[1];
	wire       wr_s    = wr_go & aw_sel_ff[2];
	wire       wr_m    = wr_go & aw_sel_ff[3];
	wire       wr_c    = wr_go & aw_sel_ff[4];
	wire       wr_ok   = wr_e | wr_f | wr_m | wr_s | wr_c;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff    <= 1'b0;
			w_hold_ff     <= 1'b0;
			aw_sel_ff     <= 5'h00;
			w_data_ff     <= 32'h00000000;
			w_strb_ff     <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SWMC_RESP_OKAY;
		end else begin
			s_axi_awready <= ~aw_hold_ff & ~aw_take;
			s_axi_wready  <= ~w_hold_ff & ~w_take;
			if (aw_take) begin
				aw_hold_ff <= 1'b1;
				aw_sel_ff  <= reg_dec(s_axi_awaddr);
			end
			if (w_take) begin
				w_hold_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `SWMC_RESP_OKAY : `SWMC_RESP_SLVERR;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_hold_ff    <= 1'b0;
				w_hold_ff     <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// byte lane gate for the mask, status and clear writes
	wire [31:0] wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}},
	                     {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
	wire [31:0] wbits = w_data_ff & wmask;

	////////////////////////////////////////////////////////////////////
	// per-source configuration, detection and edge record
	genvar g;
	generate
		for (g = 0; g < NSRC; g = g + 1) begin : g_src
			localparam [4:0] B = slot_base(g);
			wire bank_wr = (g < 3) ? wr_e : wr_f;
			wire lane_ok = w_strb_ff[B[4:3]];
			wire fire    = active(lvl_sel_ff[g], req_lvl[g], req_rise[g], req_fall[g]);
			assign hit[g] = fire & wake_en_ff[g];

			always @(posedge aclk) begin
				if (!aresetn) begin
					lvl_sel_ff[g]  <= `SWMC_LVL_RST;
					wake_en_ff[g]  <= 1'b0;
					edge_rec_ff[g] <= `SWMC_EDGE_NONE;
				end else begin
					if (bank_wr & lane_ok) begin
						lvl_sel_ff[g] <= w_data_ff[B + `SWMC_LVL_LSB +: 3];
						wake_en_ff[g] <= w_data_ff[B + `SWMC_EN_BIT];
					end
					// detection wins over a clear in the same cycle
					if (hit[g] & (lvl_sel_ff[g] == `SWMC_LVL_BOTH)) begin
						edge_rec_ff[g] <= {req_fall[g], req_rise[g]};
					end else if (clr_pulse[g]) begin
						edge_rec_ff[g] <= `SWMC_EDGE_NONE;
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// sticky status, mask, request output and interrupt
	always @* begin
		clr_pulse = {NSRC{1'b0}};
		if (wr_s | wr_c) begin
			clr_pulse = wbits[NSRC-1:0];
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			status_ff       <= {NSRC{1'b0}};
			mask_ff         <= `SWMC_MASK_RST;
			wake_request_ff <= {NSRC{1'b0}};
			irq_ff          <= 1'b0;
		end else begin
			// set beats write-one-to-clear
			status_ff <= (status_ff & ~clr_pulse) | hit;
			if (wr_m) begin
				mask_ff <= (mask_ff & ~wmask[NSRC-1:0]) | wbits[NSRC-1:0];
			end
			wake_request_ff <= hit;
			irq_ff <= |((status_ff & ~clr_pulse | hit) & mask_ff);
		end
	end

	////////////////////////////////////////////////////////////////////
	// bank images; other reserved bits read as zero
	reg [2:0]  spare_e_ff;
	reg        spare_en_ff;
	reg [31:0] bank_e;
	reg [31:0] bank_f;
	integer k;

	// spare bits only hold what software writes; they steer nothing
	always @(posedge aclk) begin
		if (!aresetn) begin
			spare_e_ff  <= `SWMC_SPARE_RST;
			spare_en_ff <= 1'h0;
		end else if (wr_e & w_strb_ff[3]) begin
			spare_e_ff  <= w_data_ff[`SWMC_SPARE_LSB +: 3];
			spare_en_ff <= w_data_ff[`SWMC_SPARE_BIT];
		end
	end

	always @* begin
		bank_e = 32'h00000000;
		bank_f = 32'h00000000;
		bank_e[`SWMC_SPARE_LSB +: 3] = spare_e_ff;
		bank_e[`SWMC_SPARE_BIT]      = spare_en_ff;
		for (k = 0; k < NSRC; k = k + 1) begin
			if (k < 3) begin
				bank_e[slot_base(k) + `SWMC_LVL_LSB +: 3]  = lvl_sel_ff[k];
				bank_e[slot_base(k) + `SWMC_EDGE_LSB +: 2] = edge_rec_ff[k];
				bank_e[slot_base(k) + `SWMC_EN_BIT]        = wake_en_ff[k];
			end else begin
				bank_f[slot_base(k) + `SWMC_LVL_LSB +: 3]  = lvl_sel_ff[k];
				bank_f[slot_base(k) + `SWMC_EDGE_LSB +: 2] = edge_rec_ff[k];
				bank_f[slot_base(k) + `SWMC_EN_BIT]        = wake_en_ff[k];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// axi4-lite read: one cycle from address take to rvalid
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `SWMC_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `SWMC_RESP_OKAY;
				case (reg_dec(s_axi_araddr))
					SEL_E:   s_axi_rdata <= bank_e;
					SEL_F:   s_axi_rdata <= bank_f;
					SEL_STS: s_axi_rdata <= {27'h0000000, status_ff};
					SEL_MSK: s_axi_rdata <= {27'h0000000, mask_ff};
					SEL_CLR: s_axi_rdata <= 32'h00000000;
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `SWMC_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule

// [swmc_checker.sv]
// checker: bus and handshake relations at the wake control ports
// assumes it is bound to swmc_wake_ctrl
`timescale 1ns/1ps
module swmc_checker (
	input wire        aclk,
	input wire        aresetn,
	input wire [31:0] s_axi_awaddr,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire ar = s_axi_arvalid && s_axi_arready;
	// the take edge loads the holds, the next edge raises bvalid
	write_resp_a: assert property (aw_w |-> ##2 s_axi_bvalid) else $error("no write response");
	read_resp_a: assert property (ar |=> s_axi_rvalid) else $error("no read response");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("second read taken");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("second write taken");
	bad_read_a: assert property (ar && s_axi_araddr > 32'h00000010 |=> s_axi_rresp == 2'h2 &&
		s_axi_rdata == 32'h00000000) else $error("unmapped read accepted");
	bad_write_a: assert property (aw_w && s_axi_awaddr > 32'h00000010 |-> ##2 s_axi_bresp == 2'h2)
		else $error("unmapped write accepted");
endmodule
bind swmc_wake_ctrl swmc_checker u_swmc_checker (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready);

// [swmc_req_model.sv]
// peripheral request lines feeding the wake control block
// assumes the bench sets the wanted levels; lines move off the clock edge
`timescale 1ns/1ps
module swmc_req_model (
	input  wire [4:0] lvl_cmd,
	output reg  [4:0] req
);
	// skewed 7 ns so the lines never change on an aclk edge
	initial req = 5'h00;
	always @(lvl_cmd) req <= #7 lvl_cmd;
endmodule

// [tb_top.sv]
// self-checking bench for the wake control block
// assumes AXI4-Lite master role and a behavioural request model
`timescale 1ns/1ps
module tb_top;
	reg aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	reg [31:0] awaddr = 0, wdata = 0, araddr = 0;
	reg [4:0] cmd = 0;
	wire [4:0] req, wake;
	wire awready, wready, bvalid, arready, rvalid, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	integer mismatches = 0, comparisons = 0;
	reg [31:0] d;
	reg [1:0] r;
	reg s;
	initial forever #20 aclk = ~aclk;
	swmc_req_model u_swmc_req_model (.lvl_cmd(cmd), .req(req));
	swmc_wake_ctrl u_swmc_wake_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.remote_rx_request(req[0]), .cec_tx_request(req[1]), .cec_rx_request(req[2]),
		.key_wake_request(req[3]), .rtc_wake_request(req[4]), .wake_request_ff(wake),
		.irq_ff(irq));
	////////////////////////////////////////////////////////////////////////////
	task chk(input [31:0] got, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("Error %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [31:0] a, input [31:0] v, input [1:0] er);
		begin
			awaddr <= a;
			wdata <= v;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			s = 0;
			while (!s) begin
				@(posedge aclk);
				if (awready) awvalid <= 1'b0;
				if (wready) wvalid <= 1'b0;
				s = bvalid;
			end
			chk(bresp, er);
			bready <= 1'b0;
			// an idle edge, so a following call never re-drives bready in this step
			@(posedge aclk);
		end
	endtask
	task rd(input [31:0] a, input [31:0] ev, input [1:0] er);
		begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			s = 0;
			while (!s) begin
				@(posedge aclk);
				if (arready) arvalid <= 1'b0;
				s = rvalid;
			end
			chk(rdata, ev);
			chk(rresp, er);
			rready <= 1'b0;
			@(posedge aclk);
		end
	endtask
	// raise request i, watch wake bit i over a fixed window, then drop it
	task pulse(input integer i, input e);
		begin
			cmd[i] <= 1'b1;
			s = 0;
			repeat (8) @(posedge aclk) s = s | wake[i];
			cmd[i] <= 1'b0;
			repeat (6) @(posedge aclk);
			chk(s, e);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	task t_reset_and_cfg;
		begin
			rd(32'h00, 32'h20202020, 2'h0);
			rd(32'h04, 32'h00002020, 2'h0);
			rd(32'h0C, 32'h00000000, 2'h0);
			wr(32'h00, 32'h00313131, 2'h0);
			wr(32'h04, 32'h00001121, 2'h0);
			rd(32'h00, 32'h00313131, 2'h0);
			rd(32'h04, 32'h00001121, 2'h0);
			rd(32'h14, 32'h00000000, 2'h2);
			wr(32'h14, 32'hFFFFFFFF, 2'h2);
		end
	endtask
	task t_enable;
		begin
			pulse(0, 1'b1);
			rd(32'h00, 32'h00313131, 2'h0);
			wr(32'h00, 32'h00303131, 2'h0);
			pulse(0, 1'b0);
			wr(32'h00, 32'h00513131, 2'h0);
			pulse(0, 1'b0);
			wr(32'h00, 32'h00313131, 2'h0);
		end
	endtask
	task t_irq;
		begin
			wr(32'h0C, 32'h0000001F, 2'h0);
			wr(32'h08, 32'h0000001F, 2'h0);
			chk(irq, 1'b0);
			cmd[3] <= 1'b1;
			repeat (6) @(posedge aclk);
			chk(irq, 1'b1);
			cmd[3] <= 1'b0;
			repeat (6) @(posedge aclk);
			rd(32'h08, 32'h00000008, 2'h0);
			wr(32'h10, 32'h00000008, 2'h0);
			rd(32'h08, 32'h00000000, 2'h0);
			chk(irq, 1'b0);
			wr(32'h0C, 32'h00000017, 2'h0);
			pulse(3, 1'b1);
			rd(32'h08, 32'h00000008, 2'h0);
			chk(irq, 1'b0);
		end
	endtask
	task t_both;
		begin
			wr(32'h00, 32'h00413131, 2'h0);
			cmd[0] <= 1'b1;
			repeat (6) @(posedge aclk);
			rd(32'h00, 32'h00453131, 2'h0);
			wr(32'h10, 32'h00000001, 2'h0);
			rd(32'h00, 32'h00413131, 2'h0);
			cmd[0] <= 1'b0;
			repeat (6) @(posedge aclk);
			rd(32'h00, 32'h00493131, 2'h0);
		end
	endtask
	// remaining rising sources, the falling rtc source and the low-level code
	task t_levels;
		begin
			pulse(1, 1'b1);
			pulse(2, 1'b1);
			cmd[4] <= 1'b1;
			repeat (6) @(posedge aclk);
			chk(wake[4], 1'b0);
			cmd[4] <= 1'b0;
			s = 0;
			repeat (8) @(posedge aclk) s = s | wake[4];
			chk(s, 1'b1);
			wr(32'h04, 32'h00000121, 2'h0);
			repeat (4) @(posedge aclk);
			chk(wake[3], 1'b1);
			wr(32'h04, 32'h00001121, 2'h0);
		end
	endtask
	task complete_run;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, mismatches);
			if (mismatches == 0 && comparisons > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_reset_and_cfg;
		t_enable;
		t_irq;
		t_both;
		t_levels;
		complete_run;
	end
	initial begin
		#200000;
		mismatches = mismatches + 1;
		complete_run;
	end
endmodule
